// >>> rtl/rre_pkg.sv
// Package of constants and types for the return and rotate execution block
`default_nettype none
package rre_pkg;
   // ----------------------------------------
   // Widths, depths and bit positions
   // ----------------------------------------
   localparam int PC_W = 15;         // Program counter width
   localparam int DATA_W = 8;        // Data word width
   localparam int FADDR_W = 7;       // File register address width
   localparam int SP_W = 3;          // Return stack pointer width
   localparam int STACK_DEPTH = 8;   // Return stack entries
   localparam int FILE_DEPTH = 128;  // File register count
   localparam int CARRY_POS = 7;     // Bit shifted out into carry
   localparam int IRQ_EN_POS = 7;    // Enable bit inside the irq control byte

   // ----------------------------------------
   // Operation select codes
   // ----------------------------------------
   localparam logic [1:0] OPC_RET_IRQ = 2'h0;  // return_from_interrupt_op
   localparam logic [1:0] OPC_RET_SUB = 2'h1;  // Subroutine return
   localparam logic [1:0] OPC_RET_LIT = 2'h2;  // return_with_literal_op
   localparam logic [1:0] OPC_ROT_LC = 2'h3;   // rotate_left_carry_op

   // ----------------------------------------
   // Destination select, reset values and cycle counts
   // ----------------------------------------
   localparam logic DEST_WORK = 1'b0;                   // Result to working_reg
   localparam logic DEST_FILE = 1'b1;                   // Result to file register
   localparam logic [PC_W-1:0] PC_RST = 15'h0000;       // Program counter after reset
   localparam logic [DATA_W-1:0] WORK_RST = 8'h00;      // working_reg after reset
   localparam logic [DATA_W-1:0] IRQCTL_RST = 8'h00;    // irq_control_reg after reset
   localparam logic [SP_W-1:0] SP_RST = 3'h0;           // Stack pointer after reset
   localparam int RET_CYCLES = 2;                       // Cycles of any return
   localparam int ROT_CYCLES = 2;                       // Cycles of a rotate incl. read

   // ----------------------------------------
   // Sequencer states, one-hot
   // ----------------------------------------
   typedef enum logic [1:0] {
      RRE_IDLE = 2'b01,    // Waiting for an operation
      RRE_FINISH = 2'b10   // Second cycle: commit results
   } rre_state_t;
endpackage
`default_nettype wire

// >>> rtl/rre_file_mem.sv
// File register memory with a registered read port and one write port
`default_nettype none
module rre_file_mem
(
   input wire logic clk,                                 // Core clock
   input wire logic rst_n,                               // Async reset, active low
   input wire logic [rre_pkg::FADDR_W-1:0] rd_addr,      // Read address
   output logic [rre_pkg::DATA_W-1:0] rd_data,           // Read data, one cycle later
   input wire logic wr_en,                               // Write strobe
   input wire logic [rre_pkg::FADDR_W-1:0] wr_addr,      // Write address
   input wire logic [rre_pkg::DATA_W-1:0] wr_data        // Write data
);
   // Storage is not reset; only the read register is
   logic [rre_pkg::DATA_W-1:0] mem [rre_pkg::FILE_DEPTH];

   // ----------------------------------------
   // Write port
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   // ----------------------------------------
   // Registered read port
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_data <= '0;
      end
      else
      begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule
`default_nettype wire

// >>> rtl/rre_exec.sv
// Execution unit for the three returns and rotate left through carry
// Function
// - Interrupt return pops stack, loads program counter
// - Interrupt return sets global enable bit seven
// - Interrupt return: two cycles, flags kept
// - Subroutine return pops stack into counter
// - Subroutine return completes in two cycles
// - Literal return loads working_reg with literal
// - Literal return loads counter, two cycles
// - Rotate left through carry, carry into bit0
// - Destination zero working_reg, one file register
`default_nettype none
module rre_exec
(
   input wire logic MCLK,                                  // Core clock, 100 MHz
   input wire logic RESET_N,                               // Async reset, active low
   input wire logic OP_VALID,                              // Operation request, taken when idle
   input wire logic [1:0] OP_SEL,                          // Operation select code
   input wire logic [rre_pkg::DATA_W-1:0] OP_LITERAL,      // Literal of the literal return
   input wire logic [rre_pkg::FADDR_W-1:0] OP_FADDR,       // File register address of rotate
   input wire logic OP_DEST,                               // Destination select of rotate
   input wire logic CALL_PUSH,                             // Push a return address
   input wire logic [rre_pkg::PC_W-1:0] CALL_ADDR,         // Address pushed
   input wire logic IRQ_ENTRY,                             // Core clears global enable
   input wire logic FILE_WR,                               // Core writes a file register
   input wire logic [rre_pkg::FADDR_W-1:0] FILE_WADDR,     // Core write address
   input wire logic [rre_pkg::DATA_W-1:0] FILE_WDATA,      // Core write data
   output logic [rre_pkg::PC_W-1:0] PC_Q,                  // Program counter
   output logic [rre_pkg::DATA_W-1:0] WORK_Q,              // working_reg
   output logic CARRY_Q,                                   // Carry flag
   output logic [rre_pkg::DATA_W-1:0] IRQCTL_Q,            // irq_control_reg
   output logic [rre_pkg::SP_W-1:0] SP_Q,                  // Return stack pointer
   output logic BUSY_Q,                                    // Operation in progress
   output logic DONE_Q                                     // One-cycle completion pulse
);
   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Pointer one entry back; wraps, as the stack has no underflow trap
   function automatic logic [rre_pkg::SP_W-1:0] sp_back(input logic [rre_pkg::SP_W-1:0] sp);
      sp_back = sp - 3'h1;
   endfunction

   // Rotate left through carry: {new carry, result}
   function automatic logic [rre_pkg::DATA_W:0] rot_lc(input logic [rre_pkg::DATA_W-1:0] v,
                                                      input logic c);
      rot_lc = {v[rre_pkg::CARRY_POS], v[rre_pkg::DATA_W-2:0], c};
   endfunction

   // ----------------------------------------
   // State declarations
   // ----------------------------------------
   rre_pkg::rre_state_t state_q, state_d;               // Sequencer state
   logic [1:0] sel_q, sel_d;                            // Latched op select
   logic [rre_pkg::DATA_W-1:0] lit_q, lit_d;            // Latched literal
   logic [rre_pkg::FADDR_W-1:0] fa_q, fa_d;             // Latched file address
   logic dest_q, dest_d;                                // Latched destination
   logic [rre_pkg::PC_W-1:0] top_q, top_d;              // Popped stack_top value
   logic [rre_pkg::PC_W-1:0] pc_d;                      // Next program counter
   logic [rre_pkg::DATA_W-1:0] work_d;                  // Next working_reg
   logic carry_d;                                       // Next carry
   logic [rre_pkg::DATA_W-1:0] irqctl_d;                // Next irq control
   logic [rre_pkg::SP_W-1:0] sp_d;                      // Next stack pointer
   logic busy_d;                                        // Next busy
   logic done_d;                                        // Next done pulse
   logic [rre_pkg::PC_W-1:0] stack_q [rre_pkg::STACK_DEPTH];  // Return stack
   logic push_en;                                       // Stack write this cycle
   logic accept;                                        // Operation taken this cycle
   logic is_ret;                                        // Accepted op is a return
   logic [rre_pkg::DATA_W-1:0] mem_rd;                  // File register read data
   logic [rre_pkg::DATA_W:0] rot_res;                   // Rotate carry and result
   logic mem_we;                                        // Memory write strobe
   logic [rre_pkg::FADDR_W-1:0] mem_wa;                 // Memory write address
   logic [rre_pkg::DATA_W-1:0] mem_wd;                  // Memory write data

   // ----------------------------------------
   // File register memory
   // ----------------------------------------
   rre_file_mem u_mem
   (
      .clk(MCLK),
      .rst_n(RESET_N),
      .rd_addr(OP_FADDR),
      .rd_data(mem_rd),
      .wr_en(mem_we),
      .wr_addr(mem_wa),
      .wr_data(mem_wd)
   );

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   // Reading the file register costs the first cycle, so the rotate commits in the second
   always_comb
   begin
      accept = OP_VALID && (state_q == rre_pkg::RRE_IDLE);
      is_ret = (OP_SEL != rre_pkg::OPC_ROT_LC);
      // A push that meets an accepted op is dropped; the core never issues both
      push_en = CALL_PUSH && !accept;
      rot_res = rot_lc(mem_rd, CARRY_Q);
      state_d = state_q;
      sel_d = sel_q;
      lit_d = lit_q;
      fa_d = fa_q;
      dest_d = dest_q;
      top_d = top_q;
      pc_d = PC_Q;
      work_d = WORK_Q;
      carry_d = CARRY_Q;
      irqctl_d = IRQCTL_Q;
      sp_d = SP_Q;
      busy_d = 1'b0;
      done_d = 1'b0;
      mem_we = FILE_WR;
      mem_wa = FILE_WADDR;
      mem_wd = FILE_WDATA;
      // Core clears global enable on interrupt entry; a set below wins
      if (IRQ_ENTRY)
      begin
         irqctl_d[rre_pkg::IRQ_EN_POS] = 1'b0;
      end
      if (push_en)
      begin
         sp_d = SP_Q + 3'h1;
      end
      case (state_q)
         rre_pkg::RRE_IDLE:
         begin
            if (accept)
            begin
               sel_d = OP_SEL;
               lit_d = OP_LITERAL;
               fa_d = OP_FADDR;
               dest_d = OP_DEST;
               state_d = rre_pkg::RRE_FINISH;
               busy_d = 1'b1;
               if (is_ret)
               begin
                  sp_d = sp_back(SP_Q);
                  top_d = stack_q[sp_back(SP_Q)];
               end
            end
         end
         rre_pkg::RRE_FINISH:
         begin
            state_d = rre_pkg::RRE_IDLE;
            done_d = 1'b1;
            if (sel_q == rre_pkg::OPC_ROT_LC)
            begin
               carry_d = rot_res[rre_pkg::DATA_W];
               if (dest_q == rre_pkg::DEST_WORK)
               begin
                  work_d = rot_res[rre_pkg::DATA_W-1:0];
               end
               else
               begin
                  mem_we = 1'b1;
                  mem_wa = fa_q;
                  mem_wd = rot_res[rre_pkg::DATA_W-1:0];
               end
            end
            else
            begin
               pc_d = top_q;
               if (sel_q == rre_pkg::OPC_RET_IRQ)
               begin
                  irqctl_d[rre_pkg::IRQ_EN_POS] = 1'b1;
               end
               if (sel_q == rre_pkg::OPC_RET_LIT)
               begin
                  work_d = lit_q;
               end
            end
         end
         default:
         begin
            state_d = rre_pkg::RRE_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state_q <= rre_pkg::RRE_IDLE;
         sel_q <= rre_pkg::OPC_RET_IRQ;
         lit_q <= rre_pkg::WORK_RST;
         fa_q <= '0;
         dest_q <= rre_pkg::DEST_WORK;
         top_q <= rre_pkg::PC_RST;
         PC_Q <= rre_pkg::PC_RST;
         WORK_Q <= rre_pkg::WORK_RST;
         CARRY_Q <= 1'b0;
         IRQCTL_Q <= rre_pkg::IRQCTL_RST;
         SP_Q <= rre_pkg::SP_RST;
         BUSY_Q <= 1'b0;
         DONE_Q <= 1'b0;
         for (int i = 0; i < rre_pkg::STACK_DEPTH; i++)
         begin
            stack_q[i] <= rre_pkg::PC_RST;
         end
      end
      else
      begin
         state_q <= state_d;
         sel_q <= sel_d;
         lit_q <= lit_d;
         fa_q <= fa_d;
         dest_q <= dest_d;
         top_q <= top_d;
         PC_Q <= pc_d;
         WORK_Q <= work_d;
         CARRY_Q <= carry_d;
         IRQCTL_Q <= irqctl_d;
         SP_Q <= sp_d;
         BUSY_Q <= busy_d;
         DONE_Q <= done_d;
         // Push writes the entry at the pointer, then the pointer advances
         if (push_en)
         begin
            stack_q[SP_Q] <= CALL_ADDR;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verification/rre_exec_checker.sv
// Assertion checker for the return and rotate execution block
`default_nettype none
module rre_exec_checker
(
   input wire logic MCLK, // Core clock
   input wire logic RESET_N, // Reset, active low
   input wire logic OP_VALID, // Request
   input wire logic [1:0] OP_SEL, // Op code
   input wire logic [7:0] OP_LITERAL, // Literal
   input wire logic OP_DEST, // Rotate destination
   input wire logic [7:0] WORK_Q, // working_reg
   input wire logic CARRY_Q, // Carry
   input wire logic [7:0] IRQCTL_Q, // irq_control_reg
   input wire logic [2:0] SP_Q, // Stack pointer
   input wire logic BUSY_Q, // Busy
   input wire logic DONE_Q // Done pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RESET_N);
   // Request taken only while idle
   sequence s_take;
      OP_VALID && !BUSY_Q;
   endsequence
   // Any of the three returns
   sequence s_ret;
      s_take ##0 OP_SEL != 2'h3;
   endsequence
   AST_TWO_CYCLES:
   assert property (s_take |=> BUSY_Q ##1 (DONE_Q && !BUSY_Q)) else $error("op not done in two");
   AST_DONE_CAUSE:
   assert property (DONE_Q |-> $past(BUSY_Q) && !BUSY_Q) else $error("done without busy");
   AST_POP_BACK:
   assert property (s_ret |=> SP_Q == $past(SP_Q) - 3'h1) else $error("pop did not step back");
   AST_IRQ_SET:
   assert property (s_take ##0 OP_SEL == 2'h0 |-> ##2 IRQCTL_Q == 8'h80)
      else $error("enable not set");
   AST_LIT_LOAD:
   assert property (s_take ##0 OP_SEL == 2'h2 |-> ##2 WORK_Q == $past(OP_LITERAL, 2))
      else $error("literal not loaded");
   AST_RET_FLAGS:
   assert property (s_ret |=> $stable(CARRY_Q) [*2]) else $error("return changed carry");
   AST_ROT_CARRY_IN:
   assert property (s_take ##0 (OP_SEL == 2'h3 && !OP_DEST) |-> ##2 WORK_Q[0] == $past(CARRY_Q, 2))
      else $error("old carry not in bit0");
   AST_ROT_FILE_DEST:
   assert property (s_take ##0 (OP_SEL == 2'h3 && OP_DEST) |=> $stable(WORK_Q) [*2])
      else $error("file rotate touched working_reg");
endmodule
bind rre_exec rre_exec_checker u_chk (.MCLK(MCLK), .RESET_N(RESET_N), .OP_VALID(OP_VALID),
   .OP_SEL(OP_SEL), .OP_LITERAL(OP_LITERAL), .OP_DEST(OP_DEST), .WORK_Q(WORK_Q),
   .CARRY_Q(CARRY_Q), .IRQCTL_Q(IRQCTL_Q), .SP_Q(SP_Q), .BUSY_Q(BUSY_Q), .DONE_Q(DONE_Q));
`default_nettype wire

// >>> verification/tb_rre_exec.sv
// Self-checking testbench for the return and rotate execution block
`default_nettype none
module tb_rre_exec;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Signals and instance
   // ----------------------------------------
   logic MCLK = 1'b0; // Core clock
   logic RESET_N = 1'b0; // Reset, active low
   logic OP_VALID = 1'b0; // Request
   logic [1:0] OP_SEL = 2'h0; // Op code
   logic [7:0] OP_LITERAL = 8'h00; // Literal
   logic [6:0] OP_FADDR = 7'h00; // Rotate address
   logic OP_DEST = 1'b0; // Rotate destination
   logic CALL_PUSH = 1'b0; // Push strobe
   logic [14:0] CALL_ADDR = 15'h0000; // Pushed address
   logic IRQ_ENTRY = 1'b0; // Enable clear
   logic FILE_WR = 1'b0; // Core write strobe
   logic [6:0] FILE_WADDR = 7'h00; // Core write address
   logic [7:0] FILE_WDATA = 8'h00; // Core write data
   logic [14:0] PC_Q; // Program counter
   logic [7:0] WORK_Q; // working_reg
   logic CARRY_Q; // Carry
   logic [7:0] IRQCTL_Q; // irq_control_reg
   logic [2:0] SP_Q; // Stack pointer
   logic BUSY_Q; // Busy
   logic DONE_Q; // Done pulse
   int n_fail = 0; // Mismatches
   int checks = 0; // Comparisons
   int cycles = 0; // Hang guard
   rre_exec dut (.MCLK(MCLK), .RESET_N(RESET_N), .OP_VALID(OP_VALID), .OP_SEL(OP_SEL),
      .OP_LITERAL(OP_LITERAL), .OP_FADDR(OP_FADDR), .OP_DEST(OP_DEST), .CALL_PUSH(CALL_PUSH),
      .CALL_ADDR(CALL_ADDR), .IRQ_ENTRY(IRQ_ENTRY), .FILE_WR(FILE_WR), .FILE_WADDR(FILE_WADDR),
      .FILE_WDATA(FILE_WDATA), .PC_Q(PC_Q), .WORK_Q(WORK_Q), .CARRY_Q(CARRY_Q),
      .IRQCTL_Q(IRQCTL_Q), .SP_Q(SP_Q), .BUSY_Q(BUSY_Q), .DONE_Q(DONE_Q));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // Request held into the busy cycle, so a refused repeat would show as a second pop
   task automatic op(input logic [1:0] sel, input logic [7:0] lit, input logic [6:0] fa,
      input logic dest);
      @(posedge MCLK);
      OP_VALID <= 1'b1;
      OP_SEL <= sel;
      OP_LITERAL <= lit;
      OP_FADDR <= fa;
      OP_DEST <= dest;
      repeat (2) @(posedge MCLK);
      OP_VALID <= 1'b0;
      #1;
      chk("done", DONE_Q, 1'b1);
   endtask
   // Single-cycle strobe on one of the side inputs
   task automatic push(input logic [14:0] a);
      @(posedge MCLK);
      CALL_PUSH <= 1'b1;
      CALL_ADDR <= a;
      @(posedge MCLK);
      CALL_PUSH <= 1'b0;
      #1;
   endtask
   task automatic t_returns;
      push(15'h1234);
      push(15'h7fff);
      push(15'h0abc);
      chk("sp", SP_Q, 3'h3);
      op(2'h0, 8'h00, 7'h00, 1'b0);
      chk("pc", PC_Q, 15'h0abc);
      chk("irqctl", IRQCTL_Q, 8'h80);
      chk("sp", SP_Q, 3'h2);
      // Core interrupt entry clears the enable again
      @(posedge MCLK);
      IRQ_ENTRY <= 1'b1;
      @(posedge MCLK);
      IRQ_ENTRY <= 1'b0;
      #1;
      chk("irqctl", IRQCTL_Q, 8'h00);
      op(2'h2, 8'hff, 7'h00, 1'b0);
      chk("work", WORK_Q, 8'hff);
      chk("pc", PC_Q, 15'h7fff);
      chk("carry", CARRY_Q, 1'b0);
      op(2'h1, 8'h00, 7'h00, 1'b0);
      chk("pc", PC_Q, 15'h1234);
      chk("sp", SP_Q, 3'h0);
      chk("work", WORK_Q, 8'hff);
      $display("test returns done");
   endtask
   task automatic t_rotate;
      @(posedge MCLK);
      FILE_WR <= 1'b1;
      FILE_WADDR <= 7'h7f;
      FILE_WDATA <= 8'h96;
      @(posedge MCLK);
      FILE_WR <= 1'b0;
      op(2'h3, 8'h00, 7'h7f, 1'b1);
      chk("carry", CARRY_Q, 1'b1);
      chk("work", WORK_Q, 8'hff);
      op(2'h3, 8'h00, 7'h7f, 1'b0);
      chk("work", WORK_Q, 8'h59);
      chk("carry", CARRY_Q, 1'b0);
      $display("test rotate done");
   endtask
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------
   // Clock, guard and main sequence
   // ----------------------------------------
   initial forever #5 MCLK = ~MCLK;
   // The whole run needs well under a hundred cycles
   always @(posedge MCLK)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_fail++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (8) @(posedge MCLK);
      RESET_N <= 1'b1;
      #1;
      chk("pc", PC_Q, 15'h0000);
      chk("irqctl", IRQCTL_Q, 8'h00);
      chk("busy", BUSY_Q, 1'b0);
      $display("test reset done");
      t_returns();
      t_rotate();
      end_of_test();
   end
endmodule
`default_nettype wire
